// [lts_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_sequencer
  import lts_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic        trig_in,
  output var  logic        sync_out,
  output var  logic        frame_valid,
  output var  logic        capture_active
);
  typedef struct packed {
    lts_state_t    state;
    logic [2:0]    mode;
    logic [TW-1:0] tint;
    logic [FW-1:0] nframes;
    logic [OW-1:0] offset;
    logic          trig_en;
    logic          stream;
    logic          acq;
    logic          go;
    logic          cap_cur;
    logic          seen;
    logic          missed;
    logic [FW-1:0] done_cnt;
    logic [TW-1:0] us_cnt;
    logic [TW-1:0] frame_len;
    logic [TW-1:0] ro_cnt;
    logic          sync;
    logic          fvalid;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } lts_main_t;

  localparam lts_main_t LTS_RST = '{
    state:   ST_IDLE,
    tint:    INT_DEF_US,
    nframes: FRAMES_DEF,
    default: '0
  };

  lts_main_t     r;
  lts_main_t     n;
  logic          us_tick;
  logic          trig_lvl;
  logic          trig_rise;
  logic          shutter;
  logic [TW-1:0] ist;
  logic [TW-1:0] offs;
  logic [TW-1:0] raise_at;
  logic [TW-1:0] deadline;
  logic          at_end;
  logic          late;
  logic          take;
  logic          wr_now;
  logic [31:0]   mask;
  logic [31:0]   wv;
  logic          hit;
  logic          close;
  logic          close_cap;
  logic          miss_set;
  logic          restart;
  logic          start;
  logic          stop;

  lts_us_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (us_tick)
  );

  lts_sync_edge u_trig (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (trig_in),
    .level   (trig_lvl),
    .rise    (trig_rise)
  );

  // Register read decode, shared by the read channel and the strobe merge.
  function automatic logic [31:0] lts_rd(input logic [7:0] a, input lts_main_t s);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      ADDR_CTRL:   v = {27'h0, s.stream, s.trig_en, s.mode};
      ADDR_TINT:   v = {6'h0, s.tint};
      ADDR_FRAMES: v = {19'h0, s.nframes};
      ADDR_OFFSET: v = {21'h0, s.offset};
      ADDR_STATUS: v = {3'h0, s.done_cnt, 10'h0, s.tint <= SHUT_MAX_US, s.missed, s.acq,
                        s.state};
      ADDR_FLEN:   v = {6'h0, s.frame_len};
      default:     v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic lts_hit(input logic [7:0] a);
    return a inside {ADDR_CTRL, ADDR_TINT, ADDR_FRAMES, ADDR_OFFSET, ADDR_STATUS, ADDR_FLEN};
  endfunction

  // Frame geometry; in shutter timing integration fills the last interval.
  assign shutter  = r.tint <= SHUT_MAX_US;
  assign ist      = shutter ? r.frame_len - r.tint : '0;
  assign offs     = (shutter && r.mode != MODE_EXT_SW) ? {{(TW-OW){1'b0}}, r.offset} : '0;
  assign raise_at = (ist > offs) ? ist - offs : '0;
  assign deadline = r.frame_len - DEADLINE_US;
  assign at_end   = us_tick && (r.us_cnt == r.frame_len - 1'b1);
  assign late     = r.us_cnt > deadline;
  assign wr_now   = r.aw_got && r.w_got && !r.bvalid;
  assign mask     = {{8{r.w_strb[3]}}, {8{r.w_strb[2]}}, {8{r.w_strb[1]}}, {8{r.w_strb[0]}}};

  // Capture decision taken at the deadline, 5 us before integration ends.
  always_comb
  begin
    case (r.mode)
      MODE_INT_HWSTART: take = r.acq && (r.go || trig_rise);
      MODE_INT_HWEN:    take = r.acq && trig_lvl;
      default:          take = r.acq;
    endcase
  end

  // Next state: sequencer first, then software writes, then output gating.
  always_comb
  begin
    n = r;
    n.fvalid = 1'b0;
    wv = 32'h0;
    hit = 1'b0;
    close = 1'b0;
    close_cap = 1'b0;
    miss_set = 1'b0;
    restart = 1'b0;
    start = 1'b0;
    stop = 1'b0;

    // An edge outside the window still arms capture for the next frame.
    if (trig_rise && r.acq && r.mode == MODE_INT_HWSTART)
      n.go = 1'b1;

    case (r.state)
      ST_IDLE:
      begin
        n.us_cnt = '0;
        n.ro_cnt = '0;
        n.frame_len = '0;
        n.seen = 1'b0;
        if (r.mode == MODE_EXT_SW)
          n.state = ST_EXT;
        else if (r.mode != MODE_SINGLE || trig_rise)
          n.state = ST_CALC;
      end
      ST_CALC:
      begin
        // One interval per cycle; at most a few hundred cycles at 10 us.
        n.cap_cur = 1'b0;
        if (!shutter)
        begin
          n.frame_len = r.tint;
          n.state = ST_FRAME;
        end
        else
        begin
          n.frame_len = r.frame_len + r.tint;
          if (n.frame_len >= READOUT_US)
            n.state = ST_FRAME;
        end
      end
      ST_FRAME:
      begin
        if (us_tick)
          n.us_cnt = r.us_cnt + 1'b1;
        hit = us_tick && (r.us_cnt == raise_at);
        if (us_tick && r.us_cnt == deadline)
          n.cap_cur = take;
        if (trig_rise && r.acq && late &&
            (r.mode == MODE_INT_HWEN || (r.mode == MODE_INT_HWSTART && !r.go)))
          miss_set = 1'b1;
        if (at_end)
        begin
          n.us_cnt = '0;
          close = 1'b1;
          close_cap = r.cap_cur;
          n.cap_cur = 1'b0;
          if (r.mode == MODE_SINGLE)
            n.state = ST_READOUT;
        end
      end
      ST_READOUT:
      begin
        // Sensor readout dead time; triggers arriving now are dropped.
        if (us_tick)
          n.ro_cnt = r.ro_cnt + 1'b1;
        if (us_tick && r.ro_cnt == READOUT_US - 1'b1)
          n.state = ST_IDLE;
      end
      ST_EXT:
      begin
        // The sync input period is the frame; the programmed time is unused.
        if (us_tick && r.us_cnt != '1)
          n.us_cnt = r.us_cnt + 1'b1;
        if (trig_rise)
        begin
          // A tick in the edge cycle belongs to the new frame, so the period is not short by one.
          n.us_cnt = {{(TW-1){1'b0}}, us_tick};
          n.seen = 1'b1;
          if (r.seen)
          begin
            n.frame_len = r.us_cnt;
            hit = 1'b1;
            close = 1'b1;
            close_cap = r.acq;
          end
        end
      end
      default:
        n.state = ST_IDLE;
    endcase

    // Frame completion; storage mode stops at the programmed count.
    if (close && close_cap)
    begin
      n.fvalid = 1'b1;
      n.done_cnt = r.done_cnt + 1'b1;
      if (!r.stream && n.done_cnt >= r.nframes)
      begin
        n.acq = 1'b0;
        n.go = 1'b0;
      end
    end

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && r.awready)
    begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;

    // Register update; out-of-range values are refused with SLVERR.
    if (wr_now)
    begin
      wv = (lts_rd(r.aw_addr, r) & ~mask) | (r.w_data & mask);
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.aw_addr)
        ADDR_CTRL:
        begin
          if (wv[2:0] > MODE_EXT_SW)
            n.bresp = RESP_SLVERR;
          else
          begin
            restart = wv[2:0] != r.mode;
            n.mode = wv[2:0];
            n.trig_en = wv[CTRL_EN_BIT];
            n.stream = wv[CTRL_STREAM_BIT];
            start = wv[CTRL_START_BIT] && mask[CTRL_START_BIT];
            stop = wv[CTRL_STOP_BIT] && mask[CTRL_STOP_BIT];
          end
        end
        ADDR_TINT:
        begin
          if (wv < 32'(INT_MIN_US) || wv > 32'(INT_MAX_US))
            n.bresp = RESP_SLVERR;
          else
          begin
            n.tint = wv[TW-1:0];
            restart = 1'b1;
          end
        end
        ADDR_FRAMES:
        begin
          if (wv == 32'h0 || wv > 32'(FRAMES_MAX))
            n.bresp = RESP_SLVERR;
          else
            n.nframes = wv[FW-1:0];
        end
        ADDR_OFFSET:
        begin
          if (wv > 32'(OFFSET_MAX_US))
            n.bresp = RESP_SLVERR;
          else
            n.offset = wv[OW-1:0];
        end
        ADDR_STATUS:
        begin
          if (r.w_data[STAT_MISSED_BIT] && mask[STAT_MISSED_BIT])
            n.missed = 1'b0;
        end
        ADDR_FLEN:
          n.bresp = RESP_OKAY;
        default:
          n.bresp = RESP_SLVERR;
      endcase
    end

    // A new mode or integration time restarts the frame from scratch.
    if (restart)
    begin
      n.state = ST_IDLE;
      n.cap_cur = 1'b0;
    end
    if (start)
    begin
      n.acq = 1'b1;
      n.go = 1'b0;
      n.done_cnt = '0;
    end
    if (stop || (restart && r.mode != n.mode))
    begin
      n.acq = 1'b0;
      n.go = 1'b0;
    end
    // A miss raised in the cycle software clears it still sticks.
    if (miss_set)
      n.missed = 1'b1;

    // Sync pulse ends at the next microsecond tick and is held low when disabled.
    if (hit)
      n.sync = 1'b1;
    else if (us_tick)
      n.sync = 1'b0;
    if (!n.trig_en || n.state == ST_IDLE)
      n.sync = 1'b0;

    // Read channel: one read at a time, answered the cycle after the address.
    if (s_axi_arvalid && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = lts_rd(s_axi_araddr, r);
      n.rresp = lts_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;

    n.arready = !n.rvalid;
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= LTS_RST;
    else
      r <= n;
  end

  // Every output is a field of the state register.
  assign s_axi_awready  = r.awready;
  assign s_axi_wready   = r.wready;
  assign s_axi_bvalid   = r.bvalid;
  assign s_axi_bresp    = r.bresp;
  assign s_axi_arready  = r.arready;
  assign s_axi_rvalid   = r.rvalid;
  assign s_axi_rdata    = r.rdata;
  assign s_axi_rresp    = r.rresp;
  assign sync_out       = r.sync;
  assign frame_valid    = r.fvalid;
  assign capture_active = r.acq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_mode_legal;
    r.mode <= MODE_EXT_SW;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("Operating mode out of range.");

  property p_tint_min;
    r.tint >= INT_MIN_US && r.tint <= INT_MAX_US;
  endproperty
  a_tint_min: assert property (p_tint_min)
    else $error("Integration time outside accepted range.");

  property p_sync_quiet;
    (!r.trig_en || r.state == ST_IDLE) |-> !sync_out;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet)
    else $error("Sync output high while disabled or idle.");

  property p_shutter_len;
    $rose(r.state == ST_FRAME) && shutter |->
      r.frame_len >= READOUT_US && r.frame_len - r.tint < READOUT_US;
  endproperty
  a_shutter_len: assert property (p_shutter_len)
    else $error("Shutter frame is not the least multiple reaching readout time.");

  property p_offset;
    r.state == ST_FRAME && r.trig_en && shutter && r.mode != MODE_EXT_SW && us_tick &&
      !wr_now && {{(TW-OW){1'b0}}, r.offset} <= r.frame_len - r.tint &&
      r.us_cnt == r.frame_len - r.tint - {{(TW-OW){1'b0}}, r.offset} |=> sync_out;
  endproperty
  a_offset: assert property (p_offset)
    else $error("Sync not raised offset before integration start.");

  property p_ext_pulse;
    r.state == ST_EXT && r.trig_en && r.seen && trig_rise && !wr_now |=> sync_out [*1];
  endproperty
  a_ext_pulse: assert property (p_ext_pulse)
    else $error("External mode missed the integration end pulse.");

  property p_ext_len;
    r.state == ST_EXT && r.seen && trig_rise && !wr_now |=> r.frame_len == $past(r.us_cnt);
  endproperty
  a_ext_len: assert property (p_ext_len)
    else $error("External period did not set the frame length.");

  property p_ss_trig;
    r.state == ST_IDLE && r.mode == MODE_SINGLE && trig_rise && !wr_now |=>
      r.state == ST_CALC ##[1:400] r.state == ST_FRAME;
  endproperty
  a_ss_trig: assert property (p_ss_trig)
    else $error("Single-shot trigger did not start one frame.");

  property p_readout;
    r.state == ST_FRAME && at_end && r.mode == MODE_SINGLE && !wr_now |=>
      r.state == ST_READOUT && r.ro_cnt == '0;
  endproperty
  a_readout: assert property (p_readout)
    else $error("Single-shot frame not followed by readout.");

  property p_frames;
    r.fvalid && !r.stream && r.done_cnt >= r.nframes |-> !r.acq;
  endproperty
  a_frames: assert property (p_frames)
    else $error("Acquisition ran past the frame count.");

  property p_late;
    r.state == ST_FRAME && r.mode == MODE_INT_HWEN && r.acq && late && trig_rise |=> r.missed;
  endproperty
  a_late: assert property (p_late)
    else $error("Late trigger not flagged as missed.");

  c_single: cover property (r.mode == MODE_SINGLE && r.fvalid);
  c_ext: cover property (r.state == ST_EXT && sync_out);
  c_missed: cover property ($rose(r.missed));
endmodule // lts_sequencer
`default_nettype wire

// [lts_pkg.sv]
`default_nettype none
package lts_pkg;
  // Clock rate and the microsecond tick derived from it.
  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned US_CYC   = CLK_HZ / US_PER_S;
  localparam int unsigned US_W     = 7;
  localparam logic [US_W-1:0] US_LAST = US_W'(US_CYC - 1);

  // Widths of the time, frame count and offset fields.
  localparam int unsigned TW = 26;
  localparam int unsigned FW = 13;
  localparam int unsigned OW = 11;

  // Sequencing times in microseconds, and frame counts.
  localparam logic [TW-1:0] READOUT_US    = 3710;
  localparam logic [TW-1:0] SHUT_MAX_US   = 3709;
  localparam logic [TW-1:0] INT_MIN_US    = 10;
  localparam logic [TW-1:0] INT_MAX_US    = 60_000_000;
  localparam logic [TW-1:0] INT_DEF_US    = 5000;
  localparam logic [TW-1:0] DEADLINE_US   = 5;
  localparam logic [OW-1:0] OFFSET_MAX_US = 1849;
  localparam logic [FW-1:0] FRAMES_MAX    = 4599;
  localparam logic [FW-1:0] FRAMES_DEF    = 1;

  // Operating modes.
  localparam logic [2:0] MODE_INT_SW      = 3'h0;
  localparam logic [2:0] MODE_INT_HWSTART = 3'h1;
  localparam logic [2:0] MODE_INT_HWEN    = 3'h2;
  localparam logic [2:0] MODE_SINGLE      = 3'h3;
  localparam logic [2:0] MODE_EXT_SW      = 3'h4;

  // Register byte addresses and field positions.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TINT   = 8'h04;
  localparam logic [7:0] ADDR_FRAMES = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FLEN   = 8'h14;
  localparam int unsigned CTRL_EN_BIT     = 3;
  localparam int unsigned CTRL_STREAM_BIT = 4;
  localparam int unsigned CTRL_START_BIT  = 8;
  localparam int unsigned CTRL_STOP_BIT   = 9;
  localparam int unsigned STAT_MISSED_BIT = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_CALC, ST_FRAME, ST_READOUT, ST_EXT} lts_state_t;

  typedef struct packed {
    logic meta;
    logic stab;
    logic prev;
  } lts_sync_t;

  typedef struct packed {
    logic [US_W-1:0] cnt;
    logic            tick;
  } lts_div_t;
endpackage
`default_nettype wire

// [lts_us_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_us_tick
  import lts_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  output var  logic tick
);
  lts_div_t r;
  lts_div_t n;

  // One-cycle enable once per microsecond; all sequencing time runs on it.
  always_comb
  begin
    n = r;
    n.tick = (r.cnt == US_LAST);
    n.cnt = n.tick ? '0 : r.cnt + 1'b1;
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  assign tick = r.tick;
endmodule // lts_us_tick
`default_nettype wire

// [lts_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_sync_edge
  import lts_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output var  logic level,
  output var  logic rise
);
  lts_sync_t r;
  lts_sync_t n;

  // Stage one feeds only stage two, so a metastable sample never reaches logic.
  always_comb
  begin
    n.meta = din;
    n.stab = r.meta;
    n.prev = r.stab;
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end

  // Level and rising edge both come from the settled stages.
  assign level = r.stab;
  assign rise  = r.stab & ~r.prev;
endmodule // lts_sync_edge
`default_nettype wire

// [lts_trig_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_trig_partner
(
  input  wire logic        aclk,
  input  wire logic        sync_out,
  input  wire logic [15:0] gen_per,
  input  wire logic [15:0] echo_dly,
  output var  logic        trig_in
);
  logic [15:0] gcnt   = 16'h0;
  logic [15:0] ecnt   = 16'h0;
  logic        sync_d = 1'h0;

  initial trig_in = 1'h0;

  // Either a generator of 2 us pulses every gen_per cycles, or an instrument that answers
  // each frame sync rise after echo_dly cycles. The answer only meets the deadline if the
  // bench keeps echo_dly below the time from the sync rise to 5 us before frame end, so a slower answer is late and can be flagged as missed.
  always @(posedge aclk)
  begin
    sync_d <= sync_out;
    gcnt   <= (gen_per == 16'h0 || gcnt >= gen_per - 16'h1) ? 16'h0 : gcnt + 16'h1;
    if (sync_out && !sync_d)
      ecnt <= 16'h1;
    else if (ecnt != 16'h0 && ecnt < echo_dly + 16'h64)
      ecnt <= ecnt + 16'h1;
    else
      ecnt <= 16'h0;
    if (gen_per != 16'h0)
      trig_in <= gcnt < 16'hfa;
    else
      trig_in <= echo_dly != 16'h0 && ecnt >= echo_dly;
  end
endmodule // lts_trig_partner
`default_nettype wire

// [lts_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_sequencer_tb;
  import lts_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, trig, sync, fv, cact, sync_d = 1'h0, trig_d = 1'h0;
  logic        awv = 1'h0, awr, wv = 1'h0, wr_rdy, bv, br = 1'h0, arv = 1'h0, arr, rv, rr = 1'h0;
  logic [7:0]  awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] gper = 16'h0, edly = 16'h0;
  logic        ext_chk = 1'h0;
  int          n_mismatch = 0, total_checks = 0, n_sync = 0, n_fv = 0, since = 0, n_late = 0;

  always #4 aclk = ~aclk;

  lts_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .trig_in(trig),
    .sync_out(sync), .frame_valid(fv), .capture_active(cact));

  lts_trig_partner i_part (.aclk(aclk), .sync_out(sync), .gen_per(gper), .echo_dly(edly),
    .trig_in(trig));

  // Counts sync rises and frames; a sync rise far from the last trigger edge is late.
  always @(posedge aclk)
  begin
    sync_d <= sync;
    trig_d <= trig;
    since  <= (trig && !trig_d) ? 1 : since + 1;
    if (sync && !sync_d)
    begin
      n_sync <= n_sync + 1;
      if (ext_chk && since > 6)
        n_late <= n_late + 1;
    end
    if (fv)
      n_fv <= n_fv + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Write with both channels offered together; waits for the answer without a cycle limit.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awa <= a;
    wd  <= v;
    awv <= 1'h1;
    wv  <= 1'h1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (awv && awr) begin ad = 1; awv <= 1'h0; end
      if (wv && wr_rdy) begin dd = 1; wv <= 1'h0; end
    end
    br <= 1'h1;
    do @(posedge aclk); while (!bv);
    br <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rr  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'h0;
    end
    while (!rv);
    v  = rdat;
    rs = rresp;
    rr <= 1'h0;
  endtask

  function automatic logic [31:0] cw(input int m, input bit en, input bit s, input bit go);
    return 32'(m) | (32'(en) << CTRL_EN_BIT) | (32'(s) << CTRL_STREAM_BIT)
      | (32'(go) << CTRL_START_BIT);
  endfunction

  task automatic test_regs();
    rd(ADDR_TINT, d, r); chk(d, 32'(INT_DEF_US));
    rd(ADDR_FRAMES, d, r); chk(d, 32'(FRAMES_DEF));
    rd(ADDR_CTRL, d, r); chk(d, 32'h0);
    wr(ADDR_TINT, 32'(INT_MIN_US) - 32'h1, RESP_SLVERR);
    wr(ADDR_TINT, 32'(INT_MIN_US), RESP_OKAY);
    rd(ADDR_TINT, d, r); chk(d, 32'(INT_MIN_US));
    wr(ADDR_FRAMES, 32'(FRAMES_MAX) + 32'h1, RESP_SLVERR);
    wr(ADDR_FRAMES, 32'(FRAMES_MAX), RESP_OKAY);
    wr(ADDR_CTRL, 32'h5, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    rd(8'h18, d, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    // The timing kind bit follows the integration time register directly; the wait is not needed for it.
    wr(ADDR_TINT, 32'(SHUT_MAX_US), RESP_OKAY);
    repeat (500) @(posedge aclk);
    rd(ADDR_STATUS, d, r); chk({31'h0, d[5]}, 32'h1);
    wr(ADDR_TINT, 32'(READOUT_US), RESP_OKAY);
    repeat (500) @(posedge aclk);
    rd(ADDR_STATUS, d, r); chk({31'h0, d[5]}, 32'h0);
    $display("regs done");
  endtask

  task automatic test_off();
    int s0;
    wr(ADDR_CTRL, cw(4, 0, 0, 0), RESP_OKAY);
    s0 = n_sync;
    gper <= 16'h9c4;
    repeat (10000) @(posedge aclk);
    gper <= 16'h0;
    chk(32'(n_sync - s0), 32'h0);
    $display("disabled sync done");
  endtask

  // External sync at a 20 us period: sync follows each edge after the first, offset has no effect.
  task automatic test_ext(input logic [31:0] t, input bit s);
    int s0, f0, l0;
    wr(ADDR_TINT, t, RESP_OKAY);
    wr(ADDR_FRAMES, 32'h2, RESP_OKAY);
    wr(ADDR_OFFSET, 32'h64, RESP_OKAY);
    wr(ADDR_CTRL, cw(4, 1, s, 0), RESP_OKAY);
    wr(ADDR_CTRL, cw(4, 1, s, 1), RESP_OKAY);
    s0 = n_sync;
    f0 = n_fv;
    l0 = n_late;
    ext_chk <= 1'h1;
    gper <= 16'h9c4;
    repeat (15000) @(posedge aclk);
    gper <= 16'h0;
    repeat (300) @(posedge aclk);
    ext_chk <= 1'h0;
    chk(32'(n_late - l0), 32'h0);
    chk(32'(n_sync - s0 >= 4), 32'h1);
    rd(ADDR_FLEN, d, r); chk(d, 32'h14);
    chk({31'h0, cact}, {31'h0, s});
    if (s) chk(32'(n_fv - f0 >= 3), 32'h1);
    else chk(32'(n_fv - f0), 32'h2);
    $display("external sync done");
  endtask

  // Modes 0 to 2 run continuously: a fresh non-shutter frame pulses sync early on.
  task automatic test_int();
    int s0, w;
    for (int m = 0; m < 3; m++)
    begin
      edly <= (m == 1) ? 16'h64 : (m == 2) ? 16'h1f4 : 16'h0;
      wr(ADDR_CTRL, cw(m, 1, 0, 1), RESP_OKAY);
      wr(ADDR_TINT, 32'(READOUT_US), RESP_OKAY);
      s0 = n_sync;
      w = 0;
      while (n_sync == s0 && w < 1000) begin @(posedge aclk); w++; end
      chk(32'(n_sync - s0), 32'h1);
      w = 0;
      while (sync && w < 200) begin @(posedge aclk); w++; end
      chk(32'(w <= 125), 32'h1);
      edly <= 16'h0;
    end
    $display("internal modes done");
  endtask

  // Three edges, the later two inside the frame: only one sync pulse. Two 1855 us intervals
  // make a 3710 us frame whose integration starts at 1855 us, so the 1849 us offset puts the
  // sync rise 6 us into the frame, about 760 to 885 cycles after the generator starts.
  task automatic test_single();
    int s0, w;
    wr(ADDR_TINT, 32'h73f, RESP_OKAY);
    wr(ADDR_OFFSET, 32'(OFFSET_MAX_US), RESP_OKAY);
    wr(ADDR_CTRL, cw(3, 1, 0, 1), RESP_OKAY);
    s0 = n_sync;
    w = 0;
    gper <= 16'h7d0;
    while (n_sync == s0 && w < 1200) begin @(posedge aclk); w++; end
    chk(32'(w >= 750 && w <= 900), 32'h1);
    repeat (3600) @(posedge aclk);
    gper <= 16'h0;
    chk(32'(n_sync - s0), 32'h1);
    $display("single shot done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence after a two-cycle reset.
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    test_regs();
    test_off();
    test_ext(32'(INT_MIN_US), 1'b0);
    test_ext(32'(INT_DEF_US), 1'b1);
    test_int();
    test_single();
    tally_and_finish();
  end

  // The tests need about 47000 cycles; a hang ends the run well before it wastes time.
  initial
  begin
    repeat (100000) @(posedge aclk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // lts_sequencer_tb
`default_nettype wire
